//--- design/fwp_flash_protect.sv
// Write and erase protection logic of a serial NOR flash, with an AXI4-Lite command port.
`include "fwp_map.svh"

module fwp_flash_protect (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic hwResetN,
  input wire logic wpN,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output fwp_pkg::fwp_array_req_s arrayReq
);
  import fwp_pkg::*;

  // ----------------------------------------------------------------------
  // Decoding functions
  // ----------------------------------------------------------------------

  // Range protection hit for one sector.
  function automatic logic rangeHit(input logic [7:0] sec, input logic [2:0] bp, input logic tb);
    logic [8:0] cnt;
    cnt = (bp == `FWP_BP_NONE) ? 9'h000 : (`FWP_SECTOR_COUNT >> (`FWP_BP_ALL - bp));
    if (tb) begin
      rangeHit = ({1'b0, sec} < cnt);
    end else begin
      rangeHit = ({1'b0, sec} >= (`FWP_SECTOR_COUNT - cnt));
    end
  endfunction : rangeHit

  // True for a mapped register offset.
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == `FWP_REG_CMD) || (a == `FWP_REG_ADDR) || (a == `FWP_REG_DATA) ||
               (a == `FWP_REG_PWD_LO) || (a == `FWP_REG_PWD_HI) ||
               (a == `FWP_REG_STATUS) || (a == `FWP_REG_QUERY);
  endfunction : isMapped

  // Byte-lane merge of a write into a stored word.
  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      mergeStrb[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : mergeStrb

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic awHeld_q, wHeld_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic [31:0] argAddr_q, argData_q, pwdLo_q, pwdHi_q;
  fwp_state_e state_q;
  logic [3:0] cnt_q;
  fwp_cmd_s cmd_q;
  logic wel_q, perr_q, status_write_disable_q, tb_q, freeze_q, lock_q;
  logic [2:0] bp_q;
  logic [1:0] protection_mode_reg_q;
  logic [63:0] pwd_q;
  logic [255:0] ppb_q, dyb_q;
  logic [31:0] otpLock_q;
  logic doWrite, launch, done, go, fail, anyProt, secProt, otpLocked, pwdMode, regLocked;
  logic [31:0] readWord;

  // ----------------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------------

  // Address and data are taken in either order; the response follows both.
  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
  assign launch = doWrite && (awAddr_q == `FWP_REG_CMD) && wStrb_q[0] && (state_q == FWP_IDLE);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FWP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= isMapped(awAddr_q) ? `FWP_RESP_OKAY : `FWP_RESP_SLVERR;
      end
      // Ready returns only after the response is taken, so one write is in flight.
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Argument registers; a command uses the address and data values standing at launch, and the password words as they stand at completion.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      argAddr_q <= 32'h0000_0000;
      argData_q <= 32'h0000_0000;
      pwdLo_q <= 32'h0000_0000;
      pwdHi_q <= 32'h0000_0000;
    end else if (doWrite) begin
      if (awAddr_q == `FWP_REG_ADDR) begin
        argAddr_q <= mergeStrb(argAddr_q, wData_q, wStrb_q);
      end
      if (awAddr_q == `FWP_REG_DATA) begin
        argData_q <= mergeStrb(argData_q, wData_q, wStrb_q);
      end
      if (awAddr_q == `FWP_REG_PWD_LO) begin
        pwdLo_q <= mergeStrb(pwdLo_q, wData_q, wStrb_q);
      end
      if (awAddr_q == `FWP_REG_PWD_HI) begin
        pwdHi_q <= mergeStrb(pwdHi_q, wData_q, wStrb_q);
      end
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read channels
  // ----------------------------------------------------------------------

  // Status word and the protection view of the sector named in the address register.
  always_comb begin
    readWord = 32'h0000_0000;
    unique case (s_axi_araddr)
      `FWP_REG_ADDR: readWord = argAddr_q;
      `FWP_REG_DATA: readWord = argData_q;
      `FWP_REG_STATUS: begin
        readWord[`FWP_SR_WIP] = (state_q == FWP_BUSY);
        readWord[`FWP_SR_WEL] = wel_q;
        readWord[`FWP_SR_BP_LO +: 3] = bp_q;
        readWord[`FWP_SR_PERR] = perr_q;
        readWord[`FWP_SR_STATUS_WRITE_DISABLE] = status_write_disable_q;
        readWord[`FWP_CR_FREEZE] = freeze_q;
        readWord[`FWP_CR_TB] = tb_q;
        readWord[`FWP_PROTECTION_MODE_REG_LO +: 2] = protection_mode_reg_q;
        readWord[`FWP_LOCK_BIT] = lock_q;
        readWord[`FWP_WP_BIT] = wpN;
      end
      `FWP_REG_QUERY: begin
        readWord[0] = rangeHit(argAddr_q[7:0], bp_q, tb_q) || !ppb_q[argAddr_q[7:0]] ||
                      !dyb_q[argAddr_q[7:0]];
        readWord[1] = rangeHit(argAddr_q[7:0], bp_q, tb_q);
        readWord[2] = ppb_q[argAddr_q[7:0]];
        readWord[3] = dyb_q[argAddr_q[7:0]];
      end
      default: readWord = 32'h0000_0000; // Password words and the command read as zero.
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `FWP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readWord;
      s_axi_rresp <= isMapped(s_axi_araddr) ? `FWP_RESP_OKAY : `FWP_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------------

  // Every command is busy for a fixed time; commands arriving meanwhile are dropped.
  assign done = (state_q == FWP_BUSY) && (cnt_q == 4'h1);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= FWP_IDLE;
      cnt_q <= 4'h0;
      cmd_q <= '0;
    end else if (!hwResetN) begin
      state_q <= FWP_IDLE;
      cnt_q <= 4'h0;
    end else begin
      unique case (state_q)
        FWP_IDLE: begin
          if (launch) begin
            state_q <= FWP_BUSY;
            cnt_q <= `FWP_OP_CYCLES;
            cmd_q <= '{op: wData_q[7:0], addr: argAddr_q, data: argData_q};
          end
        end
        FWP_BUSY: begin
          cnt_q <= cnt_q - 4'h1;
          if (done) begin
            state_q <= FWP_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Protection decisions for the command being completed
  // ----------------------------------------------------------------------

  assign pwdMode = (protection_mode_reg_q == `FWP_PROTECTION_MODE_REG_PWD);
  assign regLocked = !wpN && status_write_disable_q;
  assign secProt = rangeHit(cmd_q.addr[7:0], bp_q, tb_q) || !ppb_q[cmd_q.addr[7:0]] ||
                   !dyb_q[cmd_q.addr[7:0]];

  // Region 0 lower half carries no lock bit; its upper half sits under lock bit 0.
  assign otpLocked = (cmd_q.addr[9:4] != 6'h00) && !otpLock_q[cmd_q.addr[9:5]];

  // Bulk erase is refused if any single sector is protected.
  always_comb begin
    anyProt = 1'b0;
    for (int s = 0; s < int'(`FWP_SECTOR_COUNT); s++) begin
      anyProt = anyProt || rangeHit(8'(s), bp_q, tb_q) || !ppb_q[s] || !dyb_q[s];
    end
  end

  // All commands except write enable/disable, CLSR, SRST and the password unlock (PWDU) need the latch.
  always_comb begin
    unique case (cmd_q.op)
      `FWP_OP_WRITE_ENABLE_CMD, `FWP_OP_WRITE_DISABLE_CMD, `FWP_OP_CLSR, `FWP_OP_SRST, `FWP_OP_PWDU: go = 1'b1;
      default: go = wel_q;
    endcase
  end

  always_comb begin
    unique case (cmd_q.op)
      `FWP_OP_PP, `FWP_OP_QPP, `FWP_OP_SE: fail = secProt;
      `FWP_OP_BE: fail = anyProt;
      `FWP_OP_OTP_BYTE_PROGRAM_CMD: fail = freeze_q || otpLocked;
      `FWP_OP_PPBP, `FWP_OP_PPBE: fail = !lock_q;
      `FWP_OP_PWDU: fail = !pwdMode || ({pwdHi_q, pwdLo_q} != pwd_q);
      `FWP_OP_PWDP: fail = (protection_mode_reg_q != `FWP_PROTECTION_MODE_REG_NONE);
      `FWP_OP_ASPP: fail = (protection_mode_reg_q != `FWP_PROTECTION_MODE_REG_NONE) ||
                           ((protection_mode_reg_q & cmd_q.data[2:1]) == `FWP_PROTECTION_MODE_REG_ILLEGAL);
      default: fail = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Write enable latch and program error flag
  // ----------------------------------------------------------------------

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wel_q <= 1'b0;
    end else if (!hwResetN) begin
      wel_q <= 1'b0;
    end else if (done) begin
      unique case (cmd_q.op)
        `FWP_OP_WRITE_ENABLE_CMD: wel_q <= 1'b1;
        `FWP_OP_SRST, `FWP_OP_PP, `FWP_OP_SE, `FWP_OP_BE, `FWP_OP_WRITE_DISABLE_CMD, `FWP_OP_WRR,
        `FWP_OP_QPP, `FWP_OP_OTP_BYTE_PROGRAM_CMD: wel_q <= 1'b0;
        default: wel_q <= wel_q;
      endcase
    end
  end

  // A failing completion sets the flag ahead of a CLSR or SRST clear; a hardware reset in the same cycle clears it instead.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      perr_q <= 1'b0;
    end else if (!hwResetN) begin
      perr_q <= 1'b0;
    end else if (done && go && fail) begin
      perr_q <= 1'b1;
    end else if (done && ((cmd_q.op == `FWP_OP_CLSR) || (cmd_q.op == `FWP_OP_SRST))) begin
      perr_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Range protection, freeze and status write disable
  // ----------------------------------------------------------------------

  // Freeze only falls at power-on; hardware reset keeps it. Frozen range bits are dropped silently.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      freeze_q <= 1'b0;
      bp_q <= `FWP_BP_NONE;
      tb_q <= 1'b0;
      status_write_disable_q <= 1'b0;
    end else if (done && go && (cmd_q.op == `FWP_OP_WRR) && !regLocked) begin
      status_write_disable_q <= cmd_q.data[`FWP_SR_STATUS_WRITE_DISABLE];
      freeze_q <= freeze_q || cmd_q.data[`FWP_CR_FREEZE];
      if (!freeze_q) begin
        bp_q <= cmd_q.data[`FWP_SR_BP_LO +: 3];
        tb_q <= cmd_q.data[`FWP_CR_TB];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Persistent-bit lock, mode register and password
  // ----------------------------------------------------------------------

  // Software reset is deliberately absent here so the lock survives it.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lock_q <= 1'b1;
    end else if (!hwResetN) begin
      lock_q <= !pwdMode;
    end else if (done && go && !fail) begin
      if (cmd_q.op == `FWP_OP_PLBWR) begin
        lock_q <= 1'b0;
      end else if (cmd_q.op == `FWP_OP_PWDU) begin
        lock_q <= 1'b1;
      end
    end
  end

  // One-time bits only ever program ones to zeros.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      protection_mode_reg_q <= `FWP_PROTECTION_MODE_REG_NONE;
      pwd_q <= `FWP_PWD_RESET;
    end else if (done && go && !fail) begin
      if (cmd_q.op == `FWP_OP_ASPP) begin
        protection_mode_reg_q <= protection_mode_reg_q & cmd_q.data[2:1];
      end
      if (cmd_q.op == `FWP_OP_PWDP) begin
        pwd_q <= pwd_q & {pwdHi_q, pwdLo_q};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Per-sector bits and OTP lock bytes
  // ----------------------------------------------------------------------

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ppb_q <= `FWP_ALL_ONES_256;
    end else if (done && go && !fail && (cmd_q.op == `FWP_OP_PPBP)) begin
      ppb_q[cmd_q.addr[7:0]] <= 1'b0;
    end else if (done && go && !fail && (cmd_q.op == `FWP_OP_PPBE)) begin
      ppb_q <= `FWP_ALL_ONES_256;
    end
  end

  // Volatile bits return to unprotected on any reset, software reset included.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dyb_q <= `FWP_ALL_ONES_256;
    end else if (!hwResetN || (done && (cmd_q.op == `FWP_OP_SRST))) begin
      dyb_q <= `FWP_ALL_ONES_256;
    end else if (done && go && (cmd_q.op == `FWP_OP_DYBW)) begin
      dyb_q[cmd_q.addr[7:0]] <= cmd_q.data[0];
    end
  end

  // Lock bytes live at 0x10..0x13; a program can only clear bits.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      otpLock_q <= 32'hffff_ffff;
    end else if (done && go && !fail && (cmd_q.op == `FWP_OP_OTP_BYTE_PROGRAM_CMD) &&
                 (cmd_q.addr[9:2] == `FWP_OTP_LOCK_BASE)) begin
      otpLock_q[{cmd_q.addr[1:0], 3'h0} +: 8] <=
        otpLock_q[{cmd_q.addr[1:0], 3'h0} +: 8] & cmd_q.data[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // Array request
  // ----------------------------------------------------------------------

  // Only allowed program and erase operations reach the array engine.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      arrayReq <= '0;
    end else begin
      arrayReq.valid <= 1'b0;
      if (done && go && !fail) begin
        arrayReq.sector <= cmd_q.addr[7:0];
        arrayReq.otpAddr <= cmd_q.addr[9:0];
        arrayReq.data <= cmd_q.data[7:0];
        unique case (cmd_q.op)
          `FWP_OP_PP, `FWP_OP_QPP: begin
            arrayReq.valid <= 1'b1;
            arrayReq.kind <= FWP_KIND_PROGRAM;
          end
          `FWP_OP_SE: begin
            arrayReq.valid <= 1'b1;
            arrayReq.kind <= FWP_KIND_ERASE;
          end
          `FWP_OP_BE: begin
            arrayReq.valid <= 1'b1;
            arrayReq.kind <= FWP_KIND_BULK;
          end
          `FWP_OP_OTP_BYTE_PROGRAM_CMD: begin
            arrayReq.valid <= 1'b1;
            arrayReq.kind <= FWP_KIND_OTP;
          end
          default: arrayReq.valid <= 1'b0;
        endcase
      end
    end
  end

endmodule : fwp_flash_protect

//--- design/fwp_map.svh
// Register offsets, command codes, field positions and timing counts of the flash write guard.
`ifndef FWP_MAP_SVH
`define FWP_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on the AXI4-Lite bus)
// ----------------------------------------------------------------------
`define FWP_REG_CMD 8'h00
`define FWP_REG_ADDR 8'h04
`define FWP_REG_DATA 8'h08
`define FWP_REG_PWD_LO 8'h0c
`define FWP_REG_PWD_HI 8'h10
`define FWP_REG_STATUS 8'h14
`define FWP_REG_QUERY 8'h18

// ----------------------------------------------------------------------
// Command codes written to the command register
// ----------------------------------------------------------------------
`define FWP_OP_WRITE_ENABLE_CMD 8'h06
`define FWP_OP_WRITE_DISABLE_CMD 8'h04
`define FWP_OP_WRR 8'h01
`define FWP_OP_PP 8'h12
`define FWP_OP_QPP 8'h34
`define FWP_OP_SE 8'hdc
`define FWP_OP_BE 8'h60
`define FWP_OP_OTP_BYTE_PROGRAM_CMD 8'h42
`define FWP_OP_PPBP 8'he3
`define FWP_OP_PPBE 8'he4
`define FWP_OP_DYBW 8'he1
`define FWP_OP_PLBWR 8'ha6
`define FWP_OP_PWDU 8'he9
`define FWP_OP_PWDP 8'he8
`define FWP_OP_ASPP 8'h2f
`define FWP_OP_CLSR 8'h30
`define FWP_OP_SRST 8'hf0

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define FWP_SR_WIP 0
`define FWP_SR_WEL 1
`define FWP_SR_BP_LO 2
`define FWP_SR_PERR 6
`define FWP_SR_STATUS_WRITE_DISABLE 7
`define FWP_CR_FREEZE 8
`define FWP_CR_TB 13
`define FWP_PROTECTION_MODE_REG_LO 17
`define FWP_LOCK_BIT 24
`define FWP_WP_BIT 25
`define FWP_PROTECTION_MODE_REG_NONE 2'b11
`define FWP_PROTECTION_MODE_REG_BOOT 2'b10
`define FWP_PROTECTION_MODE_REG_PWD 2'b01
`define FWP_PROTECTION_MODE_REG_ILLEGAL 2'b00
`define FWP_PWD_RESET 64'hffff_ffff_ffff_ffff
`define FWP_ALL_ONES_256 256'hffffffff_ffffffff_ffffffff_ffffffff_ffffffff_ffffffff_ffffffff_ffffffff
`define FWP_OTP_LOCK_BASE 8'h04
`define FWP_SECTOR_COUNT 9'h100
`define FWP_BP_ALL 3'h7
`define FWP_BP_NONE 3'h0
`define FWP_RESP_OKAY 2'b00
`define FWP_RESP_SLVERR 2'b10

// ----------------------------------------------------------------------
// Timing: cycles a non-volatile operation keeps the device busy
// ----------------------------------------------------------------------
`define FWP_OP_CYCLES 4'h8

`endif

//--- design/fwp_pkg.sv
// Types shared by the flash write guard and its bench.
`include "fwp_map.svh"

package fwp_pkg;

  // ----------------------------------------------------------------------
  // Commands, states and array request kinds
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FWP_IDLE,
    FWP_BUSY
  } fwp_state_e;

  typedef enum logic [1:0] {
    FWP_KIND_PROGRAM,
    FWP_KIND_ERASE,
    FWP_KIND_BULK,
    FWP_KIND_OTP
  } fwp_kind_e;

  // Command latched at launch: opcode with its argument words.
  typedef struct packed {
    logic [7:0] op;
    logic [31:0] addr;
    logic [31:0] data;
  } fwp_cmd_s;

  // Request to the array engine, issued only for allowed operations.
  typedef struct packed {
    logic valid;
    fwp_kind_e kind;
    logic [7:0] sector;
    logic [9:0] otpAddr;
    logic [7:0] data;
  } fwp_array_req_s;

endpackage : fwp_pkg

//--- bench/fwp_checker.sv
// Checker for the bus handshakes and array requests of the flash write guard.
module fwp_checker (
  input wire logic sys_clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic s_axi_rvalid, s_axi_rready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [1:0] s_axi_bresp,
  input wire fwp_pkg::fwp_array_req_s arrayReq
);
  timeunit 1ns;
  timeprecision 100ps;
  // One clock domain; checks pause while power-on reset is low.
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire logic wTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // A write is committed the cycle after it is taken, so its answer shows two edges later.
  b_answer_a: assert property (wTake |-> ##2 s_axi_bvalid) else $error("write not answered");
  b_close_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  aw_shut_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  bad_addr_a: assert property (wTake && s_axi_awaddr > 8'h18 |-> ##2 s_axi_bresp == 2'h2)
    else $error("unmapped write not refused");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  r_close_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  ar_shut_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  // Each command keeps the device busy, so array requests never come closer.
  req_gap_a: assert property (arrayReq.valid |=> !arrayReq.valid [*7])
    else $error("array requests too close");
  cover property (arrayReq.valid);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule : fwp_checker

bind fwp_flash_protect fwp_checker chk (.*);

//--- bench/fwp_host.sv
// Host side model: an AXI4-Lite master that issues register accesses.
module fwp_host (
  input wire logic sys_clk, s_axi_awready, s_axi_wready, s_axi_bvalid,
  input wire logic s_axi_arready, s_axi_rvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [31:0] s_axi_rdata,
  output logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
  output logic [7:0] s_axi_awaddr, s_axi_araddr,
  output logic [31:0] s_axi_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle bus at time zero; later changes follow a rising edge.
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
  end
  // Address and data go out together; each is dropped once it is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  // Read waits for the answer however long it takes.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 1'h0;
  endtask : rd
endmodule : fwp_host

//--- bench/tb_top.sv
// Self-checking bench: command sequences on the flash write guard.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rstn, hwResetN, wpN, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0] s_axi_wstrb = 4'hf;
  fwp_pkg::fwp_array_req_s arrayReq;
  int failures = 0, n_tests = 0, nReq = 0, cyc = 0;
  fwp_flash_protect DUT (.*);
  fwp_host host (.*);
  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Count array requests; a hang ends the run as a mismatch.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (arrayReq.valid === 1'h1) nReq <= nReq + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("ERROR %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic st(input logic [31:0] m, exp);
    host.rd(8'h14, v);
    check("status", v & m, exp);
  endtask : st
  task automatic q(input logic [7:0] s, input logic [3:0] exp);
    host.wr(8'h04, {24'h0, s}, rsp);
    host.rd(8'h18, v);
    check("query", v & 32'hf, {28'h0, exp});
  endtask : q
  // Launch a command, see it busy, then poll until it finishes.
  task automatic cmd(input logic [7:0] o, input logic [9:0] a, input logic [31:0] d);
    host.wr(8'h04, {22'h0, a}, rsp);
    host.wr(8'h08, d, rsp);
    host.wr(8'h00, {24'h0, o}, rsp);
    st(32'h1, 32'h1);
    do host.rd(8'h14, v); while (v[0] !== 1'h0);
  endtask : cmd
  task automatic wcmd(input logic [7:0] o, input logic [9:0] a, input logic [31:0] d);
    cmd(8'h06, 10'h0, 32'h0);
    cmd(o, a, d);
  endtask : wcmd
  task automatic hwr();
    @(posedge sys_clk);
    hwResetN <= 1'h0;
    @(posedge sys_clk);
    hwResetN <= 1'h1;
  endtask : hwr
  // Main sequence; later steps rely on the state left by earlier ones.
  initial begin
    {rstn, hwResetN, wpN} = 3'h3;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'h1;
    st(32'hffffffff, 32'h03060000);
    cmd(8'h06, 10'h0, 32'h0);
    st(32'h2, 32'h2);
    cmd(8'h04, 10'h0, 32'h0);
    st(32'h2, 32'h0);
    cmd(8'h01, 10'h0, 32'h1c);
    st(32'h1c, 32'h0);
    host.wr(8'h1c, 32'h0, rsp);
    check("bresp", {30'h0, rsp}, 32'h2);
    host.rd(8'h1c, v);
    check("rresp", {30'h0, s_axi_rresp}, 32'h2);
    wcmd(8'h01, 10'h0, 32'h4);
    st(32'h201e, 32'h4);
    q(8'hff, 4'hf);
    q(8'hfb, 4'hc);
    wcmd(8'hdc, 10'hff, 32'h0);
    st(32'h40, 32'h40);
    cmd(8'h30, 10'h0, 32'h0);
    check("requests", nReq, 32'h0);
    wcmd(8'h01, 10'h0, 32'h2004);
    q(8'h00, 4'hf);
    wcmd(8'hdc, 10'hff, 32'h0);
    check("requests", nReq, 32'h1);
    wcmd(8'he1, 10'hff, 32'h0);
    q(8'hff, 4'h5);
    wcmd(8'h34, 10'hff, 32'h0);
    st(32'h40, 32'h40);
    cmd(8'h30, 10'h0, 32'h0);
    hwr();
    q(8'hff, 4'hc);
    wcmd(8'he3, 10'h0a, 32'h0);
    q(8'h0a, 4'h9);
    wcmd(8'ha6, 10'h0, 32'h0);
    cmd(8'hf0, 10'h0, 32'h0);
    st(32'h1000000, 32'h0);
    wcmd(8'he4, 10'h0, 32'h0);
    q(8'h0a, 4'h9);
    hwr();
    st(32'h1000040, 32'h1000000);
    wcmd(8'h42, 10'h10, 32'hfe);
    wcmd(8'h42, 10'h13, 32'h0);
    st(32'h40, 32'h40);
    cmd(8'h30, 10'h0, 32'h0);
    wcmd(8'h42, 10'h20, 32'h0);
    check("requests", nReq, 32'h3);
    wcmd(8'h2f, 10'h0, 32'h0);
    st(32'h60040, 32'h60040);
    cmd(8'h30, 10'h0, 32'h0);
    wcmd(8'h2f, 10'h0, 32'h4);
    st(32'h60000, 32'h40000);
    wcmd(8'h2f, 10'h0, 32'h2);
    st(32'h60040, 32'h40040);
    cmd(8'h30, 10'h0, 32'h0);
    wcmd(8'h01, 10'h0, 32'h104);
    st(32'h211c, 32'h104);
    wcmd(8'h01, 10'h0, 32'h11c);
    st(32'h215c, 32'h104);
    wcmd(8'h42, 10'h40, 32'h0);
    st(32'h40, 32'h40);
    hwr();
    st(32'h100, 32'h100);
    wcmd(8'h01, 10'h0, 32'h184);
    @(posedge sys_clk);
    wpN <= 1'h0;
    wcmd(8'h01, 10'h0, 32'h104);
    st(32'h2000082, 32'h80);
    // Fresh device: password mode first, then a plain program and a bulk erase.
    @(posedge sys_clk);
    rstn <= 1'h0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'h1;
    st(32'h1000100, 32'h1000000);
    host.wr(8'h0c, 32'h12345678, rsp);
    host.wr(8'h10, 32'h9abcdef0, rsp);
    wcmd(8'he8, 10'h0, 32'h0);
    wcmd(8'h2f, 10'h0, 32'h2);
    st(32'h1060000, 32'h1020000);
    hwr();
    st(32'h1000000, 32'h0);
    host.wr(8'h0c, 32'h0, rsp);
    cmd(8'he9, 10'h0, 32'h0);
    st(32'h1000040, 32'h40);
    host.wr(8'h0c, 32'h12345678, rsp);
    cmd(8'he9, 10'h0, 32'h0);
    st(32'h1000000, 32'h1000000);
    wcmd(8'h12, 10'h5, 32'h0);
    check("sector", {24'h0, arrayReq.sector}, 32'h5);
    wcmd(8'h60, 10'h0, 32'h0);
    check("kind", {30'h0, arrayReq.kind}, 32'h2);
    check("requests", nReq, 32'h5);
    print_verdict();
  end
endmodule : tb_top
